/* design/dual_adc_pkg.sv */
// Shared constants and types for the dual converter digital side.
// Assumes a 200 MHz system clock and an APB register port.
package dual_adc_pkg;
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned SAMPLE_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PIPE_STAGES = 4;
  localparam int unsigned WAKE_W = 12;

  // Wake-up times in ns, then cycles rounded up
  localparam int unsigned SHUTDOWN_WAKE_NS = 20000;
  localparam int unsigned STANDBY_WAKE_NS = 5400;
  localparam int unsigned IDLE_WAKE_NS = 5;
  localparam int unsigned SHUTDOWN_WAKE_CYC = (SHUTDOWN_WAKE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned STANDBY_WAKE_CYC = (STANDBY_WAKE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_WAKE_CYC = (IDLE_WAKE_NS * CLOCK_MHZ + 999) / 1000;

  // Register map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned STATUS_MODE_LSB = 0;
  localparam int unsigned STATUS_REF_LSB = 2;
  localparam int unsigned STATUS_REF_READY_BIT = 4;
  localparam int unsigned STATUS_ADC_READY_BIT = 5;
  localparam int unsigned STATUS_DRIVE_BIT = 6;
  localparam int unsigned STATUS_COUNT_LSB = 8;

  // Gray order along shutdown, standby, idle, normal
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_STANDBY = 2'h1,
    MODE_IDLE = 2'h3,
    MODE_NORMAL = 2'h2
  } power_mode_t;

  typedef enum logic [1:0] {
    REF_INTERNAL = 2'h0,
    REF_BUFFERED = 2'h1,
    REF_UNBUFFERED = 2'h2
  } ref_mode_t;
endpackage

/* design/dual_adc_core.sv */
// Dual converter digital side: sampling, latency pipe, word FIFO,
// multiplexed output bus, power modes and an APB register port.
// Assumes converter clock and pins are asynchronous to clock.
//
// Added by the designer: the placing of the registers and the APB slave port.

module word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = count != DEPTH[$clog2(DEPTH+1)-1:0];
  assign outValid = count != '0;
  assign outData = mem[rdPtr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule

module dual_adc_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic converterClock,
  input wire logic [7:0] channel_first,
  input wire logic [7:0] channel_second,
  input wire logic power_select_low,
  input wire logic power_select_high,
  input wire logic refSenseAboveHigh,
  input wire logic refSenseBelowLow,
  output logic [7:0] sample_bus,
  output logic sampleBusOe,
  output logic channelFlag,
  output logic channelFlagOe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int unsigned CW = $clog2(dual_adc_pkg::FIFO_DEPTH + 1);

  // Two-stage synchronisers; first stage read by second only
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [15:0] chanA;
  logic [15:0] chanB;
  logic convClkPrev;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
      chanA <= '0;
      chanB <= '0;
      convClkPrev <= 1'b0;
    end else begin
      syncA <= {converterClock, power_select_low, power_select_high,
                refSenseAboveHigh, refSenseBelowLow};
      syncB <= syncA;
      chanA <= {channel_first, channel_second};
      chanB <= chanA;
      convClkPrev <= syncB[4];
    end
  end

  wire convRise = syncB[4] && !convClkPrev;
  wire convFall = !syncB[4] && convClkPrev;

  dual_adc_pkg::power_mode_t mode;
  dual_adc_pkg::power_mode_t next_mode;
  dual_adc_pkg::ref_mode_t refMode;
  dual_adc_pkg::ref_mode_t next_refMode;

  // Pin code to mode
  always_comb begin
    unique case ({syncB[3], syncB[2]})
      2'b00: next_mode = dual_adc_pkg::MODE_SHUTDOWN;
      2'b01: next_mode = dual_adc_pkg::MODE_STANDBY;
      2'b10: next_mode = dual_adc_pkg::MODE_IDLE;
      2'b11: next_mode = dual_adc_pkg::MODE_NORMAL;
    endcase
  end

  // Above-high wins if comparators disagree
  assign next_refMode = syncB[1] ? dual_adc_pkg::REF_INTERNAL :
                        syncB[0] ? dual_adc_pkg::REF_UNBUFFERED :
                        dual_adc_pkg::REF_BUFFERED;

  logic [dual_adc_pkg::WAKE_W-1:0] refWait;
  logic [dual_adc_pkg::WAKE_W-1:0] adcWait;
  logic drvWait;
  wire modeChange = next_mode != mode;
  wire wasDown = mode == dual_adc_pkg::MODE_SHUTDOWN;
  wire adcWasOff = wasDown || mode == dual_adc_pkg::MODE_STANDBY;
  wire adcWillRun = next_mode == dual_adc_pkg::MODE_IDLE ||
                    next_mode == dual_adc_pkg::MODE_NORMAL;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode <= dual_adc_pkg::MODE_SHUTDOWN;
      refMode <= dual_adc_pkg::REF_INTERNAL;
      refWait <= '0;
      adcWait <= '0;
      drvWait <= 1'b0;
    end else begin
      mode <= next_mode;
      refMode <= next_refMode;
      // Unbuffered reference settles under external control
      if (modeChange && wasDown && next_refMode != dual_adc_pkg::REF_UNBUFFERED) begin
        refWait <= dual_adc_pkg::WAKE_W'(dual_adc_pkg::SHUTDOWN_WAKE_CYC);
      end else if (refWait != '0) begin
        refWait <= refWait - 1'b1;
      end
      if (modeChange && adcWasOff && adcWillRun) begin
        adcWait <= dual_adc_pkg::WAKE_W'(dual_adc_pkg::STANDBY_WAKE_CYC);
      end else if (adcWait != '0) begin
        adcWait <= adcWait - 1'b1;
      end
      drvWait <= modeChange && next_mode == dual_adc_pkg::MODE_NORMAL
                 && dual_adc_pkg::IDLE_WAKE_CYC != 0;
    end
  end

  wire refReady = !wasDown && refWait == '0;
  wire adcReady = refReady && adcWait == '0 &&
                  (mode == dual_adc_pkg::MODE_IDLE || mode == dual_adc_pkg::MODE_NORMAL);
  wire drivesOn = adcReady && !drvWait && mode == dual_adc_pkg::MODE_NORMAL;

  // Latency pipe stepped by rising edges
  logic [15:0] pipeData [dual_adc_pkg::PIPE_STAGES];
  logic [dual_adc_pkg::PIPE_STAGES-1:0] pipeValid;
  logic fifoInReady;
  wire stepPipe = convRise && fifoInReady;
  // Signed input to offset binary by inverting the sign bit
  wire [15:0] sampledPair = {~chanB[15], chanB[14:8], ~chanB[7], chanB[6:0]};

  generate
    for (genvar s = 0; s < dual_adc_pkg::PIPE_STAGES; s++) begin : g_pipe
      // Stage input chosen at elaboration, so no stage indexes below zero
      logic [15:0] stageData;
      logic stageValid;
      if (s == 0) begin : g_head
        assign stageData = sampledPair;
        assign stageValid = adcReady;
      end else begin : g_body
        assign stageData = pipeData[s-1];
        assign stageValid = pipeValid[s-1];
      end
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          pipeData[s] <= '0;
          pipeValid[s] <= 1'b0;
        end else if (stepPipe) begin
          pipeData[s] <= stageData;
          pipeValid[s] <= stageValid;
        end
      end
    end
  endgenerate

  logic holdOutput;
  logic fifoOutValid;
  logic [15:0] fifoOutData;
  logic [CW-1:0] fifoCount;
  wire popWord = convRise && fifoOutValid && !holdOutput;

  word_fifo #(
    .WIDTH(16),
    .DEPTH(dual_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(stepPipe && pipeValid[dual_adc_pkg::PIPE_STAGES-1]),
    .inReady(fifoInReady),
    .inData(pipeData[dual_adc_pkg::PIPE_STAGES-1]),
    .outValid(fifoOutValid),
    .outReady(popWord),
    .outData(fifoOutData),
    .count(fifoCount)
  );

  // Output latch runs in every mode, only the enables follow the mode
  logic [7:0] secondWord;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sample_bus <= 8'h00;
      secondWord <= 8'h00;
      channelFlag <= 1'b0;
      sampleBusOe <= 1'b0;
      channelFlagOe <= 1'b0;
    end else begin
      sampleBusOe <= drivesOn;
      channelFlagOe <= drivesOn;
      if (convRise) begin
        channelFlag <= 1'b1;
        if (popWord) begin
          sample_bus <= fifoOutData[15:8];
          secondWord <= fifoOutData[7:0];
        end
      end else if (convFall) begin
        channelFlag <= 1'b0;
        sample_bus <= secondWord;
      end
    end
  end

  // APB slave, answers in the second access cycle
  wire apbAccess = psel && penable && !pready;
  wire hitCtrl = paddr == dual_adc_pkg::CTRL_OFFSET;
  wire hitStatus = paddr == dual_adc_pkg::STATUS_OFFSET;
  wire [31:0] statusWord = (32'(mode) << dual_adc_pkg::STATUS_MODE_LSB)
    | (32'(refMode) << dual_adc_pkg::STATUS_REF_LSB)
    | (32'(refReady) << dual_adc_pkg::STATUS_REF_READY_BIT)
    | (32'(adcReady) << dual_adc_pkg::STATUS_ADC_READY_BIT)
    | (32'(drivesOn) << dual_adc_pkg::STATUS_DRIVE_BIT)
    | (32'(fifoCount) << dual_adc_pkg::STATUS_COUNT_LSB);
  wire [31:0] ctrlWord = 32'(holdOutput) << dual_adc_pkg::CTRL_HOLD_BIT;
  wire [31:0] readWord = hitCtrl ? ctrlWord : hitStatus ? statusWord : 32'h0000_0000;
  wire badAccess = !(hitCtrl || (hitStatus && !pwrite));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      holdOutput <= dual_adc_pkg::CTRL_RESET[dual_adc_pkg::CTRL_HOLD_BIT];
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && badAccess;
      prdata <= (apbAccess && !pwrite) ? readWord : 32'h0000_0000;
      if (apbAccess && pwrite && hitCtrl) begin
        holdOutput <= pwdata[dual_adc_pkg::CTRL_HOLD_BIT];
      end
    end
  end
endmodule

/* bench/dual_adc_monitor.sv */
// Port checker for the dual converter core.
// Assumes one clock domain with a synchronous active-low reset.
module dual_adc_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic converterClock,
  input wire logic power_select_low,
  input wire logic power_select_high,
  input wire logic sampleBusOe,
  input wire logic channelFlag,
  input wire logic channelFlagOe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire okAddr = paddr == 12'h000 || (paddr == 12'h004 && !pwrite);
  sequence accessStart;
    psel && $rose(penable);
  endsequence
  sequence oneWait;
    !pready ##1 pready;
  endsequence
  apb_wait_a: assert property (accessStart |-> oneWait) else $error("pready timing");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  apb_err_a: assert property (pready |-> pslverr == !okAddr) else $error("pslverr wrong");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  oe_pair_a: assert property (sampleBusOe == channelFlagOe) else $error("oe split");
  oe_normal_a: assert property ($rose(sampleBusOe) |->
    $past(power_select_low, 3) && $past(power_select_high, 3)) else $error("oe early");
  off_tristate_a: assert property ((!(power_select_low && power_select_high)) [*6]
    |-> !sampleBusOe) else $error("oe not off");
  flag_rise_a: assert property ($rose(channelFlag) |-> $past(converterClock, 3))
    else $error("flag rose off edge");
  flag_fall_a: assert property ($fell(channelFlag) |-> !$past(converterClock, 3))
    else $error("flag fell off edge");
endmodule

bind dual_adc_core dual_adc_monitor i_monitor (.clock(clock), .rst_n(rst_n),
  .converterClock(converterClock), .power_select_low(power_select_low),
  .power_select_high(power_select_high), .sampleBusOe(sampleBusOe),
  .channelFlag(channelFlag), .channelFlagOe(channelFlagOe), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

/* bench/sample_receiver.sv */
// Downstream receiver model: sorts bus words by the channel flag.
// Assumes registered core outputs on the same system clock.
module sample_receiver (
  input wire logic clock,
  input wire logic [7:0] sample_bus,
  input wire logic sampleBusOe,
  input wire logic channelFlag,
  output logic [7:0] firstWord,
  output logic [7:0] secondWord
);
  logic lastFlag = 1'b0;
  // Only flag edges mark a new word; a tri-stated bus is ignored
  always_ff @(posedge clock) begin
    lastFlag <= channelFlag;
    if (sampleBusOe && channelFlag && !lastFlag) firstWord <= sample_bus;
    if (sampleBusOe && !channelFlag && lastFlag) secondWord <= sample_bus;
  end
endmodule

/* bench/dual_adc_output_mux_power_modes_bench.sv */
// Self-checking bench: power modes, sample stream, FIFO hold, APB.
// Assumes the receiver model and bound checker are compiled first.
module dual_adc_output_mux_power_modes_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst_n = 0, converterClock = 0, psLow = 0, psHigh = 0;
  logic psel = 0, penable = 0, pwrite = 0, busOe, flag, flagOe, pready, pslverr, err;
  logic [7:0] chFirst = 8'h00, chSecond = 8'h00, sampleBus, rxFirst, rxSecond;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] vals [4] = '{8'h80, 8'h00, 8'h7f, 8'h01};
  int phase = 0, rises = 0, err_total = 0, tests_run = 0;

  always #2.5 clock = ~clock;

  // Ten cycles a level so the pin synchronisers see every edge
  always @(posedge clock) begin
    phase <= (phase == 19) ? 0 : phase + 1;
    if (phase == 0) begin
      converterClock <= 1'b1;
      rises <= rises + 1;
    end
    if (phase == 10) begin
      converterClock <= 1'b0;
      chFirst <= vals[rises % 4];
      chSecond <= vals[(rises + 1) % 4];
    end
  end

  dual_adc_core i_dut (.clock(clock), .rst_n(rst_n), .converterClock(converterClock),
    .channel_first(chFirst), .channel_second(chSecond), .power_select_low(psLow),
    .power_select_high(psHigh), .refSenseAboveHigh(1'b1), .refSenseBelowLow(1'b0),
    .sample_bus(sampleBus), .sampleBusOe(busOe), .channelFlag(flag),
    .channelFlagOe(flagOe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  sample_receiver i_rx (.clock(clock), .sample_bus(sampleBus), .sampleBusOe(busOe),
    .channelFlag(flag), .firstWord(rxFirst), .secondWord(rxSecond));

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No limit of its own: pready ends the wait for the answer, else the watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic modeIs(input logic [1:0] m);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[1:0]), 32'(m));
  endtask

  task automatic waitOe(input logic want, input int limit);
    int n;
    n = 0;
    while (busOe !== want && n < limit) begin
      @(posedge clock);
      n++;
    end
    check(32'(busOe), 32'(want));
  endtask

  task automatic regTest;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, dual_adc_pkg::CTRL_RESET);
    apb(1'b0, 12'h00c, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h004, 32'hffffffff);
    check(32'(err), 32'h1);
  endtask

  task automatic streamCheck;
    // Let one full converter period pass with drivers on, so both words are fresh
    repeat (20) @(posedge clock);
    repeat (3) begin
      do @(posedge clock); while (phase != 8);
      check(32'(flag), 32'h1);
      check(32'(rxFirst), 32'(vals[(rises + 2) % 4] ^ 8'h80));
      check(32'(rxSecond), 32'(vals[(rises + 2) % 4] ^ 8'h80));
      do @(posedge clock); while (phase != 18);
      check(32'(flag), 32'h0);
      check(32'(rxSecond), 32'(vals[(rises + 3) % 4] ^ 8'h80));
    end
  endtask

  task automatic holdTest;
    logic [7:0] kept;
    apb(1'b1, 12'h000, 32'h1);
    repeat (400) @(posedge clock);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[11:8]), 32'h8);
    kept = rxFirst;
    repeat (40) @(posedge clock);
    check(32'(rxFirst), 32'(kept));
  endtask

  initial begin
    #200us;
    err_total++;
    print_verdict;
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check(32'(busOe), 32'h0);
    modeIs(dual_adc_pkg::MODE_SHUTDOWN);
    regTest;
    psHigh <= 1'b1;
    repeat (8) @(posedge clock);
    modeIs(dual_adc_pkg::MODE_STANDBY);
    check(32'(busOe), 32'h0);
    psLow <= 1'b1;
    // Reference wake of 4000 cycles dominates the converter wake here
    repeat (3900) @(posedge clock);
    check(32'(busOe), 32'h0);
    waitOe(1'b1, 300);
    // Pipe and FIFO refill before the first valid word reaches the bus
    repeat (160) @(posedge clock);
    streamCheck;
    psHigh <= 1'b0;
    waitOe(1'b0, 8);
    modeIs(dual_adc_pkg::MODE_IDLE);
    repeat (100) @(posedge clock);
    psHigh <= 1'b1;
    waitOe(1'b1, 8);
    streamCheck;
    psLow <= 1'b0;
    waitOe(1'b0, 8);
    modeIs(dual_adc_pkg::MODE_STANDBY);
    psLow <= 1'b1;
    // Converter wake of 1080 cycles from standby
    repeat (1000) @(posedge clock);
    check(32'(busOe), 32'h0);
    waitOe(1'b1, 200);
    holdTest;
    psLow <= 1'b0;
    psHigh <= 1'b0;
    waitOe(1'b0, 8);
    print_verdict;
  end
endmodule
